// file: front_panel_controller.sv
// Front-panel key decoding and operating state of the temperature monitor.
//
// What this block does
// - Excitation key tap inverts source enable; remote may set it.
// - Units key swaps volts and kelvin, lighting matching lamp.
// - Kelvin uses remotely chosen curve: built-in or user (1024 pts).
// - Short setpoint tap swaps reading/setpoint view; lamp shows setpoint.
// - Holding setpoint over one second updates setpoint, flashing word.
// - In setpoint view, long presses alternate 273.15 K and reading.
// - In reading view, long press loads setpoint with latest reading.
// - Scale key steps gain: 10, 100, 1000 K full scale.
// - Rel key swaps absolute and relative; remote may set mode.
// - Output is gain times temperature, minus setpoint when relative.
// - Remote may write arbitrary gain and arbitrary setpoint.
// - Units state shared between key and remote, readable.
// - Disabled excitation stops readings until enabled again.
// - Results arrive five per second; latest one is used.
`timescale 1ns/1ps
`default_nettype none
module front_panel_controller (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire panel_pkg::key_tap_t key_tap,
   input wire logic setpoint_key_down,
   input wire panel_pkg::remote_cmd_t remote_cmd,
   input wire logic sample_valid,
   input wire logic [panel_pkg::TEMP_W-1:0] sample_temp,
   output logic excitation_enable,
   output logic display_units_k,
   output logic curve_user,
   output logic show_setpoint,
   output logic [panel_pkg::TEMP_W-1:0] setpoint_value,
   output logic [panel_pkg::GAIN_W-1:0] output_gain,
   output logic output_rel,
   output logic [panel_pkg::TEMP_W-1:0] reading_value,
   output logic reading_valid,
   output logic [panel_pkg::OUT_W-1:0] scaled_out,
   output logic flash_word,
   output panel_pkg::lamps_t lamps
);
   logic excite_q;
   logic units_q;
   logic curve_q;
   logic view_q;
   logic rel_q;
   logic next_freeze_q;
   logic have_q;
   panel_pkg::scale_t scale_q;
   panel_pkg::scale_t scale_d;
   logic [panel_pkg::TEMP_W-1:0] setp_q;
   logic [panel_pkg::TEMP_W-1:0] setp_d;
   logic [panel_pkg::GAIN_W-1:0] gain_q;
   logic [panel_pkg::GAIN_W-1:0] gain_d;
   logic [panel_pkg::TEMP_W-1:0] read_q;
   logic [panel_pkg::OUT_W-1:0] out_q;
   logic [panel_pkg::CNT_W-1:0] flash_cnt_q;
   logic [3:0] flash_left_q;
   logic flash_q;
   logic short_tap;
   logic long_press;
   logic excite_d;
   logic units_d;
   logic curve_d;
   logic rel_d;
   logic view_d;
   panel_pkg::scale_t scale_next;
   logic flash_phase_end;

   // Fixed gain for each front-panel scale step.
   function automatic logic [panel_pkg::GAIN_W-1:0] gain_of(
      input panel_pkg::scale_t s);
      case (s)
         panel_pkg::SCALE_10K: gain_of = panel_pkg::GAIN_10K;
         panel_pkg::SCALE_1000K: gain_of = panel_pkg::GAIN_1000K;
         default: gain_of = panel_pkg::GAIN_100K;
      endcase
   endfunction

   // Shared bit update: a host write of the field beats a same-cycle key
   // tap, so the host always reads back exactly what it wrote.
   function automatic logic next_bit(
      input logic we,
      input logic value,
      input logic tap,
      input logic cur);
      if (we) next_bit = value;
      else if (tap) next_bit = !cur;
      else next_bit = cur;
   endfunction

   key_press_timer u_timer (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .key_down(setpoint_key_down),
      .short_tap(short_tap),
      .long_press(long_press)
   );

   // Scale steps cycle through the three fixed spans; a remote gain
   // leaves the cycle and the next key press restarts at 10 K.
   assign scale_d = (scale_q == panel_pkg::SCALE_10K) ? panel_pkg::SCALE_100K :
                    (scale_q == panel_pkg::SCALE_100K) ?
                    panel_pkg::SCALE_1000K : panel_pkg::SCALE_10K;
   assign gain_d = remote_cmd.gain_we ? remote_cmd.gain :
                   gain_of(scale_d);

   // A host gain marks the scale as user, so the panel cycle restarts.
   assign scale_next = remote_cmd.gain_we ? panel_pkg::SCALE_USER :
                       (key_tap.scale ? scale_d : scale_q);

   // Next value of each operating bit; excitation, units and mode are shared by keys and host, curve is set by the host only.
   assign excite_d = next_bit(remote_cmd.excite_we, remote_cmd.excite,
                              key_tap.excite, excite_q);
   assign units_d = next_bit(remote_cmd.units_we, remote_cmd.units_k,
                             key_tap.units, units_q);
   assign rel_d = next_bit(remote_cmd.mode_we, remote_cmd.rel,
                           key_tap.rel, rel_q);
   assign curve_d = remote_cmd.curve_we ? remote_cmd.curve_user :
                    curve_q;
   // The view moves only on a completed short tap, never on a long hold.
   assign view_d = short_tap ? !view_q : view_q;

   // Setpoint source: remote write wins over a same-cycle long press.
   wire load_freeze = view_q && next_freeze_q;
   wire [panel_pkg::TEMP_W-1:0] capture = load_freeze ?
      panel_pkg::FREEZE_POINT : read_q;
   wire long_ok = long_press && (load_freeze || have_q);
   assign setp_d = remote_cmd.setpoint_we ? remote_cmd.setpoint :
                   capture;

   // Signed product: relative mode may swing below zero.
   wire signed [panel_pkg::TEMP_W:0] delta = output_rel ?
      $signed({1'b0, read_q}) - $signed({1'b0, setp_q}) :
      $signed({1'b0, read_q});
   wire signed [panel_pkg::TEMP_W+panel_pkg::GAIN_W:0] prod =
      delta * $signed({1'b0, gain_q});

   // Operating state; key actions and remote writes share the excitation, units and mode bits.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         excite_q <= panel_pkg::RST_EXCITE;
         units_q <= panel_pkg::RST_UNITS_K;
         curve_q <= 1'b0;
         rel_q <= panel_pkg::RST_REL;
         view_q <= 1'b0;
      end else begin
         excite_q <= excite_d;
         units_q <= units_d;
         curve_q <= curve_d;
         rel_q <= rel_d;
         view_q <= view_d;
      end
   end

   // Setpoint, gain and the alternation memory for long presses.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         setp_q <= panel_pkg::RST_SETPOINT;
         gain_q <= panel_pkg::RST_GAIN;
         scale_q <= panel_pkg::SCALE_100K;
         next_freeze_q <= 1'b1;
      end else begin
         if (remote_cmd.setpoint_we || long_ok) setp_q <= setp_d;
         if (long_ok && view_q) next_freeze_q <= !next_freeze_q;
         if (remote_cmd.gain_we || key_tap.scale) gain_q <= gain_d;
         scale_q <= scale_next;
      end
   end

   // Latest reading is held; none are accepted while excitation is off.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         read_q <= '0;
         have_q <= 1'b0;
         out_q <= '0;
      end else begin
         if (!excite_q) have_q <= 1'b0;
         else if (sample_valid) begin
            read_q <= sample_temp;
            have_q <= 1'b1;
         end
         out_q <= prod[panel_pkg::OUT_W-1:0];
      end
   end

   // End of one blink phase of the update word.
   assign flash_phase_end = (flash_cnt_q ==
      panel_pkg::CNT_W'(panel_pkg::FLASH_CYCLES - 1));

   // Flash the update word for a fixed number of blink phases.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         flash_cnt_q <= '0;
         flash_left_q <= '0;
         flash_q <= 1'b0;
      end else if (long_ok) begin
         flash_cnt_q <= '0;
         flash_left_q <= 4'(panel_pkg::FLASH_BLINKS);
         flash_q <= 1'b1;
      end else if (flash_left_q != 4'h0) begin
         if (flash_phase_end) begin
            flash_cnt_q <= '0;
            flash_left_q <= flash_left_q - 4'h1;
            flash_q <= (flash_left_q != 4'h1) && !flash_q;
         end else begin
            flash_cnt_q <= flash_cnt_q + 1'b1;
         end
      end
   end

   // Outputs and lamps.
   assign excitation_enable = excite_q;
   assign display_units_k = units_q;
   assign curve_user = curve_q;
   assign show_setpoint = view_q;
   assign setpoint_value = setp_q;
   assign output_gain = gain_q;
   assign output_rel = rel_q;
   assign reading_value = read_q;
   assign reading_valid = have_q && excite_q;
   assign scaled_out = out_q;
   assign flash_word = flash_q;
   assign lamps.kelvin = units_q;
   assign lamps.volts = !units_q;
   assign lamps.setpoint = view_q;
   assign lamps.rel = rel_q;
endmodule
`default_nettype wire

// file: front_panel_controller_tb.sv
// Self-checking bench for the front-panel controller.
`timescale 1ns/1ps
`default_nettype none
module front_panel_controller_tb;
   logic clk_sys, reset_n, sv, ee, uk, cu, ss, orl, rvl, fw;
   logic [23:0] st, spv, rdv;
   logic [15:0] og;
   logic [31:0] so, d;
   logic [63:0] w;
   panel_pkg::key_tap_t kt;
   logic kd;
   panel_pkg::remote_cmd_t rc, v;
   panel_pkg::lamps_t lm;
   int error_cnt = 0, samples_checked = 0, seed = 32'h7DC09EB8;
   int ex = 1, un = 1, g = 100, ix = 1, cv, vw, sp, rl, rd, rv, op, r, tk;
   int gtab [3] = '{panel_pkg::GAIN_10K, panel_pkg::GAIN_100K,
      panel_pkg::GAIN_1000K};
   front_panel_controller DUT (.clk_sys(clk_sys), .reset_n(reset_n),
      .key_tap(kt), .setpoint_key_down(kd), .remote_cmd(rc),
      .sample_valid(sv), .sample_temp(st), .excitation_enable(ee),
      .display_units_k(uk), .curve_user(cu), .show_setpoint(ss),
      .setpoint_value(spv), .output_gain(og), .output_rel(orl),
      .reading_value(rdv), .reading_valid(rvl), .scaled_out(so),
      .flash_word(fw), .lamps(lm));
   operator_model opm (.clk_sys(clk_sys), .key_tap(kt),
      .setpoint_key_down(kd));
   // Free-running 20 MHz clock.
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("mismatches=%0d checks=%0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic rpulse(input panel_pkg::remote_cmd_t c);
      @(posedge clk_sys);
      rc <= c;
      @(posedge clk_sys);
      rc <= '0;
   endtask
   // Three clocks cover the two-cycle lag of the scaled output.
   task automatic compare_all();
      d = {8'h00, rd[23:0]} - (rl ? sp : 0);
      repeat (3) @(posedge clk_sys);
      #1;
      check(ee, ex);
      check({uk, lm.kelvin, lm.volts}, {un[0], un[0], ~un[0]});
      check(cu, cv);
      check({ss, lm.setpoint}, {2{vw[0]}});
      check(fw, 1'b0);
      check(og, g);
      check({orl, lm.rel}, {2{rl[0]}});
      check(so, d * g);
      check(spv, sp);
      check({rvl, rdv}, {rv[0], rd[23:0]});
   endtask
   // Watchdog: the run needs a few thousand clocks at most.
   initial begin
      #2000000;
      error_cnt++;
      conclude();
   end
   // Random mix of keys, samples and host writes against a model.
   initial begin
      reset_n = 1'b0;
      rc = '0;
      sv = 1'b0;
      st = '0;
      repeat (6) @(posedge clk_sys);
      reset_n <= 1'b1;
      compare_all();
      for (int i = 0; i < 80; i++) begin
         op = $unsigned($random(seed)) % 8;
         r = $random(seed);
         v = '0;
         case (op)
            0: begin
               opm.tap(4'h8);
               ex = !ex;
            end
            1: begin
               opm.tap(4'h4);
               un = !un;
            end
            2: begin
               opm.tap(4'h2);
               ix = (ix + 1) % 3;
               g = gtab[ix];
            end
            3: begin
               opm.tap(4'h1);
               rl = !rl;
            end
            4: begin
               opm.hold(2 + (r & 3));
               vw = !vw;
            end
            5: begin
               // A quarter of these present data with no valid pulse.
               tk = ex & (r[24] | r[25]);
               @(posedge clk_sys);
               sv <= r[24] | r[25];
               st <= r[23:0];
               @(posedge clk_sys);
               sv <= 1'b0;
               rd = tk ? r & 32'h00FFFFFF : rd;
               rv = tk ? 1 : rv;
            end
            6: begin
               w = {r, $random(seed)};
               v = w[49:0];
               rpulse(v);
            end
            default: begin
               v.excite_we = 1'b1;
               v.excite = r[0];
               v.gain_we = 1'b1;
               v.gain = r[15:0];
               fork
                  opm.tap(4'hA);
                  rpulse(v);
               join
            end
         endcase
         if (v.excite_we) ex = v.excite;
         if (v.units_we) un = v.units_k;
         if (v.curve_we) cv = v.curve_user;
         if (v.setpoint_we) sp = v.setpoint;
         if (v.gain_we) g = v.gain;
         if (v.gain_we) ix = 2;
         if (v.mode_we) rl = v.rel;
         if (!ex) rv = 0;
         compare_all();
      end
      conclude();
   end
endmodule
`default_nettype wire

// file: front_panel_monitor.sv
// Port assertions for the front-panel controller.
`timescale 1ns/1ps
`default_nettype none
module front_panel_monitor (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire panel_pkg::key_tap_t key_tap,
   input wire logic setpoint_key_down,
   input wire panel_pkg::remote_cmd_t remote_cmd,
   input wire logic sample_valid,
   input wire logic [23:0] sample_temp,
   input wire logic excitation_enable,
   input wire logic display_units_k,
   input wire logic curve_user,
   input wire logic show_setpoint,
   input wire logic [23:0] setpoint_value,
   input wire logic [15:0] output_gain,
   input wire logic output_rel,
   input wire logic [23:0] reading_value,
   input wire logic reading_valid,
   input wire logic [31:0] scaled_out,
   input wire panel_pkg::lamps_t lamps
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // Modulo 2**32 product, so signedness of the difference does not matter.
   logic [31:0] diff;
   logic [31:0] exp_out;
   assign diff = {8'h00, reading_value} - (output_rel ? setpoint_value : 0);
   assign exp_out = diff * {16'h0000, output_gain};
   sequence s_short_tap;
      !setpoint_key_down ##1 setpoint_key_down [*3] ##1 !setpoint_key_down;
   endsequence
   a_excite_tap: assert property (
      key_tap.excite && !remote_cmd.excite_we
      |=> excitation_enable != $past(excitation_enable))
      else $error("excite tap");
   a_excite_host: assert property (
      remote_cmd.excite_we
      |=> excitation_enable == $past(remote_cmd.excite))
      else $error("excite host");
   a_units_tap: assert property (
      key_tap.units && !remote_cmd.units_we
      |=> display_units_k != $past(display_units_k))
      else $error("units");
   a_units_lamp: assert property (
      lamps.kelvin == display_units_k && lamps.volts != display_units_k)
      else $error("lamp");
   a_curve_host: assert property (
      remote_cmd.curve_we
      |=> curve_user == $past(remote_cmd.curve_user))
      else $error("curve");
   a_view_tap: assert property (
      s_short_tap |=> ##[0:1] $changed(show_setpoint))
      else $error("view");
   a_scale_step: assert property (
      key_tap.scale && !remote_cmd.gain_we
      && output_gain == panel_pkg::GAIN_100K
      |=> output_gain == panel_pkg::GAIN_1000K) else $error("scale");
   a_rel_tap: assert property (
      key_tap.rel && !remote_cmd.mode_we
      |=> output_rel != $past(output_rel)) else $error("rel");
   a_out_scale: assert property (
      1'b1 |=> scaled_out == $past(exp_out)) else $error("out");
   a_gain_host: assert property (
      remote_cmd.gain_we
      |=> output_gain == $past(remote_cmd.gain)) else $error("gain");
   a_dark_idle: assert property (
      !excitation_enable |-> !reading_valid) else $error("dark");
   a_dark_resume: assert property (
      $rose(excitation_enable) |-> !reading_valid)
      else $error("stale reading after enable");
   a_latest: assert property (
      sample_valid && excitation_enable
      |=> reading_value == $past(sample_temp)) else $error("sample");
endmodule
bind front_panel_controller front_panel_monitor mon (.*);
`default_nettype wire

// file: key_press_timer.sv
// Short/long press classifier for the held setpoint key.
`timescale 1ns/1ps
`default_nettype none
module key_press_timer (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic key_down,
   output logic short_tap,
   output logic long_press
);
   logic [panel_pkg::CNT_W-1:0] hold_q;
   logic [panel_pkg::CNT_W-1:0] hold_d;
   logic fired_q;
   logic down_q;
   wire at_limit = (hold_q ==
      panel_pkg::CNT_W'(panel_pkg::LONG_PRESS_CYCLES - 1));
   wire released = down_q && !key_down;

   // One long action per hold; a release after it yields no tap.
   assign long_press = key_down && !fired_q && at_limit;
   assign short_tap = released && !fired_q;
   assign hold_d = (key_down && !at_limit) ? hold_q + 1'b1 :
                   (key_down ? hold_q : '0);

   // Hold counter saturates so a very long hold never fires twice.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         hold_q <= '0;
         fired_q <= 1'b0;
         down_q <= 1'b0;
      end else begin
         hold_q <= hold_d;
         down_q <= key_down;
         fired_q <= key_down && (fired_q || long_press);
      end
   end
endmodule
`default_nettype wire

// file: operator_model.sv
// Behavioural operator pressing the front-panel keys.
`timescale 1ns/1ps
`default_nettype none
module operator_model (
   input wire logic clk_sys,
   output var panel_pkg::key_tap_t key_tap,
   output var logic setpoint_key_down
);
   // Keys start released so nothing is seen during reset.
   initial begin
      key_tap = '0;
      setpoint_key_down = 1'b0;
   end
   // A debounced tap lasts exactly one clock.
   task automatic tap(input panel_pkg::key_tap_t k);
      @(posedge clk_sys);
      key_tap <= k;
      @(posedge clk_sys);
      key_tap <= '0;
   endtask
   // Brief hold only: a long press would need twenty million clocks.
   task automatic hold(input int n);
      @(posedge clk_sys);
      setpoint_key_down <= 1'b1;
      repeat (n) @(posedge clk_sys);
      setpoint_key_down <= 1'b0;
   endtask
endmodule
`default_nettype wire

// file: panel_pkg.sv
// Shared constants and types for the front-panel controller.
package panel_pkg;
   // Clock rate and timing.
   localparam int CLK_HZ = 20000000;
   localparam int LONG_PRESS_MS = 1000;
   localparam int LONG_PRESS_CYCLES = CLK_HZ / 1000 * LONG_PRESS_MS;
   localparam int FLASH_MS = 250;
   localparam int FLASH_CYCLES = CLK_HZ / 1000 * FLASH_MS;
   localparam int FLASH_BLINKS = 6;
   localparam int CURVE_POINTS_MAX = 1024;
   // Fixed-point widths: temperature in units of 0.01 K.
   localparam int TEMP_W = 24;
   localparam int GAIN_W = 16;
   localparam int OUT_W = 32;
   localparam int CNT_W = 25;
   // Gain in millivolts per kelvin.
   localparam logic [GAIN_W-1:0] GAIN_10K = 16'h03E8;
   localparam logic [GAIN_W-1:0] GAIN_100K = 16'h0064;
   localparam logic [GAIN_W-1:0] GAIN_1000K = 16'h000A;
   localparam logic [TEMP_W-1:0] FREEZE_POINT = 24'h006AB3;
   // Reset values.
   localparam logic RST_EXCITE = 1'b1;
   localparam logic RST_UNITS_K = 1'b1;
   localparam logic RST_REL = 1'b0;
   localparam logic [TEMP_W-1:0] RST_SETPOINT = 24'h000000;
   localparam logic [GAIN_W-1:0] RST_GAIN = 16'h0064;

   typedef enum logic [1:0] {SCALE_10K, SCALE_100K, SCALE_1000K, SCALE_USER}
      scale_t;

   // Key strobes as one group.
   typedef struct packed {
      logic excite;
      logic units;
      logic scale;
      logic rel;
   } key_tap_t;

   // Remote write strobes with their values.
   typedef struct packed {
      logic excite_we;
      logic excite;
      logic units_we;
      logic units_k;
      logic curve_we;
      logic curve_user;
      logic setpoint_we;
      logic [TEMP_W-1:0] setpoint;
      logic gain_we;
      logic [GAIN_W-1:0] gain;
      logic mode_we;
      logic rel;
   } remote_cmd_t;

   // Indicator lamps.
   typedef struct packed {
      logic kelvin;
      logic volts;
      logic setpoint;
      logic rel;
   } lamps_t;
endpackage
